// ===== src/sia_pkg.sv
package sia_pkg;

    // Command codes from upstream controller
    localparam logic [3:0] CMD_DEACT_REQ = 4'h0;
    localparam logic [3:0] CMD_CLEAR = 4'h1;
    localparam logic [3:0] CMD_TEST_SINGLE = 4'h2;
    localparam logic [3:0] CMD_TEST_CONT = 4'h3;
    localparam logic [3:0] CMD_SYNC_LOST = 4'h4;
    localparam logic [3:0] CMD_ACT_REQ = 4'h8;
    localparam logic [3:0] CMD_ACT_REQ_LOOP = 4'hA;
    localparam logic [3:0] CMD_SWITCH_THROUGH = 4'hC;
    localparam logic [3:0] CMD_SWITCH_LOOP = 4'hE;
    localparam logic [3:0] CMD_DEACT_CONFIRM = 4'hF;

    // Indication codes towards upstream controller
    localparam logic [3:0] IND_INTERIM_WAIT = 4'h0;
    localparam logic [3:0] IND_RX_UNSYNCED = 4'h4;
    localparam logic [3:0] IND_ACT_REQ = 4'h8;
    localparam logic [3:0] IND_ILLEGAL_VIOLATION = 4'hB;
    localparam logic [3:0] IND_ACT_COMPLETE = 4'hC;
    localparam logic [3:0] IND_DEACT_DONE = 4'hF;

    // Transmit selections
    localparam logic [2:0] TX_INFO0 = 3'h0;
    localparam logic [2:0] TX_INFO2 = 3'h2;
    localparam logic [2:0] TX_TRANSPARENT = 3'h3;
    localparam logic [2:0] TX_INFO4 = 3'h4;
    localparam logic [2:0] TX_SINGLE_PULSE = 3'h5;
    localparam logic [2:0] TX_CONT_PULSE = 3'h6;

    // Timing: clock, line frame and timer lengths
    localparam int CLK_HZ = 125000000;
    localparam int FRAME_US = 250;
    localparam int FRAME_CYCLES = CLK_HZ / 1000000 * FRAME_US;
    localparam int INTERIM_MS = 8;
    localparam int RX_IDLE_MS = 16;
    localparam int DEACT_MAX_MS = 32;
    localparam int FRAMES_PER_MS = 1000 / FRAME_US;
    localparam logic [7:0] INTERIM_FRAMES = 8'(INTERIM_MS * FRAMES_PER_MS);
    localparam logic [7:0] RX_IDLE_FRAMES = 8'(RX_IDLE_MS * FRAMES_PER_MS);
    localparam logic [7:0] DEACT_MAX_FRAMES = 8'(DEACT_MAX_MS * FRAMES_PER_MS);
    // Continuous test: one-bit pulses at 96 kHz
    localparam int CONT_PULSE_HZ = 96000;
    localparam int CONT_PULSE_CYCLES = CLK_HZ / CONT_PULSE_HZ;

    // States, Gray coded along activation path
    typedef enum logic [3:0] {
        SIA_RESET = 4'h0,
        SIA_DEACT = 4'h1,
        SIA_LEVEL_DET = 4'h3,
        SIA_PEND_ACT = 4'h2,
        SIA_WAIT_SWITCH = 4'h6,
        SIA_ACTIVE = 4'h7,
        SIA_LOST_FRAME = 4'h5,
        SIA_LOST_UP = 4'h4,
        SIA_PEND_DEACT = 4'hC,
        SIA_WAIT_CONFIRM = 4'hD,
        SIA_TEST_SINGLE = 4'hF,
        SIA_TEST_CONT = 4'hE
    } sia_state_e;

    // Received line conditions
    typedef struct packed {
        logic info0; // Idle line
        logic info3; // INFO 3 received
        logic framed; // Receiver synchronous
        logic violation; // Illegal code violation seen
    } sia_rx_s;

    // Transmit control to line side
    typedef struct packed {
        logic [2:0] sel;
        logic pulse_pos; // Test pulse positive
        logic pulse_neg; // Test pulse negative
        logic loop_close; // Analog loop closed
        logic transparent; // B and D channels pass
    } sia_tx_s;

endpackage

// ===== src/sia_activation_fsm.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Deactivated: output 0000 while level seen until 8 ms, else 1111.
// - Indication depends on state, plus level and timer when deactivated and mode in pending activation, repeated while state lasts.
// - Command codes decoded per table; NT adds 0100, 1100, 1110.
// - Clear command from any state: reset, send INFO 0, ignore line.
// - Violation indication 1011 only when its enable bit is set.
// - Test state entered from any non-test state, not test to test.
// - Single-pulse test sends isolated alternating pulses.
// - Continuous test sends back-to-back alternating pulses.
// - Deactivated sends nothing; activate by line level or command.
// - NT: level detected gives indication 1000, waits for activation command.
// - NT: activation or loop activation sends INFO 2, waits INFO 3.
// - NT: loop activation closes analog loop in pending activation.
// - NT: after INFO 3 keep INFO 2 until switch-through.
// - Switch-through: activated, INFO 4, transparent; 1110 closes loop.
// - Framing lost when activated: lost-framing state, indication 0100.
// - NT: sync-lost command when activated sends INFO 2.
// - Deactivation sends INFO 0; leave after 16 ms idle or 32 ms.
// - Then wait with 1111 until confirm returns to deactivated.
// - LT: level or activation command goes straight to pending activation.
// - LT: sync loss sends INFO 2; INFO 3 again resumes INFO 4.
// - Activation indication 1100 when synchronous and activated.
// - Hardware reset or clear gives reset state, indication 0000.
// - Single test one pulse per frame; continuous one-bit pulses 96 kHz.
// - B and D transparent only activated or forced code 011; else ones.
module sia_activation_fsm
    import sia_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic nt_mode_in,
    input wire logic frame_strobe_in,
    input wire logic [3:0] cmd_code_in,
    input wire sia_rx_s rx_in,
    input wire logic illegal_violation_report_en_in,
    input wire logic sw_control_in,
    input wire logic [2:0] forced_tx_code_in,
    output logic [3:0] ind_code_out,
    output sia_tx_s tx_out,
    output logic frame_tick_out
);

    sia_state_e state_ff;
    sia_state_e nxt_state;
    logic [15:0] frame_cnt_ff;
    logic [7:0] timer_ff;
    logic [7:0] idle_cnt_ff;
    logic [15:0] pulse_cnt_ff;
    logic pulse_pol_ff;
    logic pulse_on_ff;
    logic violation_ff;
    logic [3:0] ind_ff;
    sia_tx_s tx_ff;
    logic [3:0] cmd_ff;
    logic frame_tick;
    logic cont_tick;
    logic cmd_take;
    logic state_change;

    // Frame divider: one-cycle enable every 250 us
    assign frame_tick = (frame_cnt_ff == 16'(FRAME_CYCLES - 1));
    assign cont_tick = (pulse_cnt_ff == 16'(CONT_PULSE_CYCLES - 1));
    assign frame_tick_out = frame_tick;

    always_ff @(posedge clk_in)
    begin
        if (reset_in || frame_tick)
            frame_cnt_ff <= 16'h0000;
        else
            frame_cnt_ff <= frame_cnt_ff + 16'h0001;
    end

    // Command sampled once per host frame; caller holds it every frame
    assign cmd_take = frame_strobe_in;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            cmd_ff <= CMD_DEACT_CONFIRM;
        else if (cmd_take)
            cmd_ff <= cmd_code_in;
    end

    // Decoded commands; NT-only codes mode qualified
    wire cmd_valid = cmd_take;
    wire is_clear = cmd_valid && (cmd_code_in == CMD_CLEAR);
    wire is_test1 = cmd_valid && (cmd_code_in == CMD_TEST_SINGLE);
    wire is_test2 = cmd_valid && (cmd_code_in == CMD_TEST_CONT);
    wire is_deact = cmd_valid && (cmd_code_in == CMD_DEACT_REQ);
    wire is_ar = cmd_valid && (cmd_code_in == CMD_ACT_REQ);
    wire is_arl = cmd_valid && (cmd_code_in == CMD_ACT_REQ_LOOP);
    wire any_act_request = is_ar || is_arl;
    wire is_confirm = cmd_valid && (cmd_code_in == CMD_DEACT_CONFIRM);
    wire is_sync_lost = cmd_valid && nt_mode_in && (cmd_code_in == CMD_SYNC_LOST);
    wire switch_through_cmd = cmd_valid && nt_mode_in && (cmd_code_in == CMD_SWITCH_THROUGH);
    wire switch_through_loopback = cmd_valid && nt_mode_in && (cmd_code_in == CMD_SWITCH_LOOP);
    wire in_test = (state_ff == SIA_TEST_SINGLE) || (state_ff == SIA_TEST_CONT);
    // Line ignored while clear held
    wire clear_held = (cmd_ff == CMD_CLEAR);
    wire level_seen = !rx_in.info0 && !clear_held;
    wire timer_done_8 = (timer_ff >= INTERIM_FRAMES);
    wire timer_done_32 = (timer_ff >= DEACT_MAX_FRAMES);
    wire idle_done_16 = (idle_cnt_ff >= RX_IDLE_FRAMES);

    // Next state; clear wins, then test, then deactivation request, then per-state moves
    always_comb
    begin
        nxt_state = state_ff;
        if (is_clear)
            nxt_state = SIA_RESET;
        else if (is_test1 && !in_test)
            nxt_state = SIA_TEST_SINGLE;
        else if (is_test2 && !in_test)
            nxt_state = SIA_TEST_CONT;
        else if (is_deact && state_ff != SIA_WAIT_CONFIRM && state_ff != SIA_DEACT
                 && state_ff != SIA_LEVEL_DET)
            nxt_state = SIA_PEND_DEACT;
        else
        begin
            case (state_ff)
                SIA_RESET, SIA_TEST_SINGLE, SIA_TEST_CONT:
                    if (is_confirm)
                        nxt_state = SIA_DEACT;
                SIA_DEACT:
                    if (any_act_request)
                        nxt_state = SIA_PEND_ACT;
                    else if (level_seen)
                        nxt_state = nt_mode_in ? SIA_LEVEL_DET : SIA_PEND_ACT;
                SIA_LEVEL_DET:
                    if (any_act_request)
                        nxt_state = SIA_PEND_ACT;
                    else if (rx_in.info0)
                        nxt_state = SIA_DEACT;
                SIA_PEND_ACT:
                    if (rx_in.info3)
                        nxt_state = nt_mode_in ? SIA_WAIT_SWITCH : SIA_ACTIVE;
                SIA_WAIT_SWITCH:
                    if (switch_through_cmd || switch_through_loopback)
                        nxt_state = SIA_ACTIVE;
                SIA_ACTIVE:
                    if (is_sync_lost)
                        nxt_state = SIA_LOST_UP;
                    else if (!rx_in.framed)
                        nxt_state = SIA_LOST_FRAME;
                SIA_LOST_FRAME:
                    if (rx_in.info3 && rx_in.framed)
                        nxt_state = SIA_ACTIVE;
                SIA_LOST_UP:
                    if (switch_through_cmd || switch_through_loopback)
                        nxt_state = SIA_ACTIVE;
                SIA_PEND_DEACT:
                    if (idle_done_16 || timer_done_32)
                        nxt_state = SIA_WAIT_CONFIRM;
                SIA_WAIT_CONFIRM:
                    if (is_confirm)
                        nxt_state = SIA_DEACT;
                default:
                    nxt_state = SIA_RESET;
            endcase
        end
    end

    assign state_change = (nxt_state != state_ff);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            state_ff <= SIA_RESET;
        else
            state_ff <= nxt_state;
    end

    // State timer in frames, restarted on each state entry
    always_ff @(posedge clk_in)
    begin
        if (reset_in || state_change)
            timer_ff <= 8'h00;
        else if (frame_tick && timer_ff != 8'hFF)
            timer_ff <= timer_ff + 8'h01;
    end

    // Continuous INFO 0 counter, restarted when idle begins
    always_ff @(posedge clk_in)
    begin
        if (reset_in || state_change || !rx_in.info0)
            idle_cnt_ff <= 8'h00;
        else if (frame_tick && idle_cnt_ff != 8'hFF)
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
    end

    // Test pulse timing: single per frame, continuous at 96 kHz
    always_ff @(posedge clk_in)
    begin
        if (reset_in || cont_tick)
            pulse_cnt_ff <= 16'h0000;
        else
            pulse_cnt_ff <= pulse_cnt_ff + 16'h0001;
    end

    wire single_slot = (state_ff == SIA_TEST_SINGLE) && frame_tick;
    wire cont_slot = (state_ff == SIA_TEST_CONT) && cont_tick;

    always_ff @(posedge clk_in)
    begin
        if (reset_in || !in_test)
        begin
            pulse_pol_ff <= 1'b0;
            pulse_on_ff <= 1'b0;
        end
        else if (single_slot || cont_slot)
        begin
            pulse_pol_ff <= !pulse_pol_ff;
            pulse_on_ff <= 1'b1;
        end
        else if (state_ff == SIA_TEST_SINGLE && cont_tick)
            pulse_on_ff <= 1'b0; // One bit wide, then gap
    end

    // Violation seen this frame; a new violation beats the frame clear
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            violation_ff <= 1'b0;
        else if (rx_in.violation && illegal_violation_report_en_in)
            violation_ff <= 1'b1;
        else if (frame_tick)
            violation_ff <= 1'b0;
    end

    // Indication: per state, plus level and timer when deactivated and mode in pending activation; violation overrides when enabled
    logic [3:0] ind_sel;
    always_comb
    begin
        case (state_ff)
            SIA_RESET: ind_sel = IND_INTERIM_WAIT;
            SIA_DEACT: ind_sel = (level_seen && !timer_done_8) ? IND_INTERIM_WAIT : IND_DEACT_DONE;
            SIA_LEVEL_DET: ind_sel = IND_ACT_REQ;
            SIA_PEND_ACT: ind_sel = nt_mode_in ? IND_ACT_REQ : IND_RX_UNSYNCED;
            SIA_WAIT_SWITCH: ind_sel = IND_ACT_COMPLETE;
            SIA_ACTIVE: ind_sel = IND_ACT_COMPLETE;
            SIA_LOST_FRAME: ind_sel = IND_RX_UNSYNCED;
            SIA_LOST_UP: ind_sel = IND_ACT_COMPLETE;
            SIA_PEND_DEACT: ind_sel = IND_INTERIM_WAIT;
            SIA_WAIT_CONFIRM: ind_sel = IND_DEACT_DONE;
            SIA_TEST_SINGLE: ind_sel = IND_INTERIM_WAIT;
            SIA_TEST_CONT: ind_sel = IND_INTERIM_WAIT;
            default: ind_sel = IND_INTERIM_WAIT;
        endcase
    end

    // Enable gates the output too, so clearing it mid-frame takes effect on the next clock edge
    wire violation_shown = violation_ff && illegal_violation_report_en_in;
    wire [3:0] ind_final = violation_shown ? IND_ILLEGAL_VIOLATION : ind_sel;

    // Transmit selection per state; forced code 011 opens data path
    logic [2:0] tx_sel;
    always_comb
    begin
        case (state_ff)
            SIA_PEND_ACT, SIA_WAIT_SWITCH, SIA_LOST_FRAME, SIA_LOST_UP: tx_sel = TX_INFO2;
            SIA_ACTIVE: tx_sel = TX_INFO4;
            SIA_TEST_SINGLE: tx_sel = TX_SINGLE_PULSE;
            SIA_TEST_CONT: tx_sel = TX_CONT_PULSE;
            default: tx_sel = TX_INFO0;
        endcase
    end

    wire forced_open = sw_control_in && (forced_tx_code_in == TX_TRANSPARENT);
    wire loop_now = (state_ff == SIA_PEND_ACT && cmd_ff == CMD_ACT_REQ_LOOP)
                    || (state_ff == SIA_ACTIVE && cmd_ff == CMD_SWITCH_LOOP && nt_mode_in);

    // Registered outputs
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ind_ff <= IND_INTERIM_WAIT;
            tx_ff <= '0;
        end
        else
        begin
            ind_ff <= ind_final;
            tx_ff.sel <= tx_sel;
            tx_ff.pulse_pos <= in_test && pulse_on_ff && pulse_pol_ff;
            tx_ff.pulse_neg <= in_test && pulse_on_ff && !pulse_pol_ff;
            tx_ff.loop_close <= loop_now;
            tx_ff.transparent <= (state_ff == SIA_ACTIVE) || forced_open;
        end
    end

    assign ind_code_out = ind_ff;
    assign tx_out = tx_ff;

endmodule // sia_activation_fsm
`default_nettype wire

// ===== testbench/sia_fsm_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sia_fsm_chk
    import sia_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic nt_mode_in,
    input wire logic frame_strobe_in,
    input wire logic [3:0] cmd_code_in,
    input wire sia_rx_s rx_in,
    input wire logic illegal_violation_report_en_in,
    input wire logic sw_control_in,
    input wire logic [2:0] forced_tx_code_in,
    input wire logic [3:0] ind_code_out,
    input wire sia_tx_s tx_out,
    input wire logic frame_tick_out
);
    // One clock domain, synchronous reset
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // Command taken on a frame strobe, guarded by the registered outputs
    sequence cmd_s(logic [3:0] c, logic g);
        frame_strobe_in && cmd_code_in == c && g;
    endsequence
    // Outputs lag the state, so guards look at registered selections
    wire logic in_test = tx_out.sel inside {TX_SINGLE_PULSE, TX_CONT_PULSE};
    // Cycles since the last frame tick, to check the divider period
    logic [15:0] tick_gap_ff;
    logic tick_seen_ff;
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            tick_gap_ff <= 16'h0000;
            tick_seen_ff <= 1'b0;
        end
        else if (frame_tick_out)
        begin
            tick_gap_ff <= 16'h0000;
            tick_seen_ff <= 1'b1;
        end
        else
            tick_gap_ff <= tick_gap_ff + 16'h0001;
    end

    reset_state_a:
        assert property ($fell(reset_in) |-> ind_code_out == IND_INTERIM_WAIT && tx_out.sel == TX_INFO0)
        else $error("outputs not at reset values");
    clear_cmd_a:
        assert property (cmd_s(CMD_CLEAR, 1'b1) |-> ##2 ind_code_out == IND_INTERIM_WAIT && tx_out.sel == TX_INFO0)
        else $error("clear command not obeyed");
    test_entry_a:
        assert property (cmd_s(CMD_TEST_SINGLE, !in_test) |-> ##2 tx_out.sel == TX_SINGLE_PULSE)
        else $error("single pulse test not entered");
    test_lock_a:
        assert property (cmd_s(CMD_TEST_CONT, tx_out.sel == TX_SINGLE_PULSE) |-> ##2 tx_out.sel == TX_SINGLE_PULSE)
        else $error("test to test switch taken");
    deact_tx_a:
        assert property (ind_code_out == IND_DEACT_DONE |-> tx_out.sel == TX_INFO0)
        else $error("transmitting while deactivated");
    switch_thru_a:
        assert property (cmd_s(CMD_SWITCH_THROUGH, nt_mode_in && rx_in.framed && tx_out.sel == TX_INFO2
            && ind_code_out == IND_ACT_COMPLETE) |-> ##2 tx_out.sel == TX_INFO4 && tx_out.transparent)
        else $error("switch through not obeyed");
    deact_req_a:
        assert property (cmd_s(CMD_DEACT_REQ, tx_out.sel != TX_INFO0 && !in_test) |-> ##2 tx_out.sel == TX_INFO0)
        else $error("deactivation not started");
    lost_frame_a:
        assert property (tx_out.sel == TX_INFO4 && $fell(rx_in.framed) |->
            ##2 ind_code_out == IND_RX_UNSYNCED && (nt_mode_in || tx_out.sel == TX_INFO2))
        else $error("framing loss not reported");
    lt_resume_a:
        assert property (!nt_mode_in && ind_code_out == IND_RX_UNSYNCED && rx_in.info3 && rx_in.framed
            |-> ##[1:3] tx_out.sel == TX_INFO4)
        else $error("no resume on info 3");
    viol_gate_a:
        assert property (ind_code_out == IND_ILLEGAL_VIOLATION |-> $past(illegal_violation_report_en_in))
        else $error("violation reported while disabled");
    frame_period_a:
        assert property (frame_tick_out && tick_seen_ff |-> tick_gap_ff == 16'(FRAME_CYCLES - 1))
        else $error("frame tick period wrong");
endmodule // sia_fsm_chk
`default_nettype wire

// ===== testbench/sia_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sia_ctrl_model #(
    parameter int PERIOD = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [3:0] cmd_req_in,
    output logic frame_strobe_out,
    output logic [3:0] cmd_code_out
);
    logic [7:0] cnt_ff = 8'h00;
    logic strobe_ff = 1'b0;
    // Frame pulse every PERIOD cycles, none while in reset
    always @(negedge clk_in)
    begin
        cnt_ff <= (reset_in || cnt_ff == 8'(PERIOD - 1)) ? 8'h00 : cnt_ff + 8'h01;
        strobe_ff <= !reset_in && cnt_ff == 8'(PERIOD - 1);
    end
    assign frame_strobe_out = strobe_ff;
    // Same code repeated every frame until the bench changes it
    assign cmd_code_out = cmd_req_in;
endmodule // sia_ctrl_model
`default_nettype wire

// ===== testbench/tb_s_interface_activation_fsm.sv
`timescale 1ns/100ps
`default_nettype none
module tb_s_interface_activation_fsm
    import sia_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic nt_mode = 1'b1;
    logic [3:0] cmd_req = 4'h5;
    sia_rx_s rx = sia_rx_s'(4'h8);
    logic en = 1'b0;
    logic sw = 1'b0;
    logic [2:0] forced = 3'h0;
    wire logic strobe;
    wire logic [3:0] cmd;
    wire logic [3:0] ind;
    wire sia_tx_s tx;
    int mismatches = 0;
    int num_checks = 0;

    // Free-running 125 MHz clock
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end

    sia_ctrl_model u_ctrl (.clk_in, .reset_in, .cmd_req_in(cmd_req), .frame_strobe_out(strobe), .cmd_code_out(cmd));
    sia_activation_fsm u_dut (.clk_in, .reset_in, .nt_mode_in(nt_mode), .frame_strobe_in(strobe),
        .cmd_code_in(cmd), .rx_in(rx), .illegal_violation_report_en_in(en), .sw_control_in(sw),
        .forced_tx_code_in(forced), .ind_code_out(ind), .tx_out(tx), .frame_tick_out());

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Three frames let any command act and both registers settle
    task automatic drive(input logic [3:0] c, input logic [3:0] r);
        cmd_req = c;
        rx = sia_rx_s'(r);
        repeat (30) @(negedge clk_in);
    endtask
    task automatic step(input logic [3:0] c, input logic [3:0] r, input logic [3:0] ei, input logic [2:0] es);
        drive(c, r);
        chk(ind, ei);
        chk({1'b0, tx.sel}, {1'b0, es});
    endtask
    function automatic logic flag(input int what);
        case (what)
            0: return tx.pulse_pos;
            1: return tx.pulse_neg;
            2: return ind == IND_ILLEGAL_VIOLATION;
            default: return tx.pulse_pos | tx.pulse_neg;
        endcase
    endfunction
    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_for(input int what, input int limit);
        int n = 0;
        while (flag(what) !== 1'b1 && n < limit)
        begin
            @(negedge clk_in);
            n++;
        end
        chk({3'h0, flag(what)}, 4'h1);
        if (n >= limit)
            tally_and_finish();
    endtask

    task automatic t_violation();
        chk(ind, IND_INTERIM_WAIT);
        en = 1'b1;
        drive(4'h5, 4'h9);
        wait_for(2, 64000);
        reset_in = 1'b1;
        en = 1'b0;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
    endtask
    task automatic t_forced();
        sw = 1'b1;
        forced = TX_TRANSPARENT;
        drive(4'h5, 4'h8);
        chk({3'h0, tx.transparent}, 4'h1);
        sw = 1'b0;
        drive(4'h5, 4'h8);
        chk({3'h0, tx.transparent}, 4'h0);
    endtask
    task automatic t_nt_activation();
        step(CMD_DEACT_CONFIRM, 4'h8, IND_DEACT_DONE, TX_INFO0);
        drive(4'h5, 4'h0);
        chk({1'b0, tx.sel}, {1'b0, TX_INFO0});
        chk(ind, IND_ACT_REQ);
        step(CMD_ACT_REQ_LOOP, 4'h0, IND_ACT_REQ, TX_INFO2);
        chk({3'h0, tx.loop_close}, 4'h1);
        step(CMD_ACT_REQ, 4'h0, IND_ACT_REQ, TX_INFO2);
        step(4'h5, 4'h6, IND_ACT_COMPLETE, TX_INFO2);
        step(CMD_SWITCH_THROUGH, 4'h6, IND_ACT_COMPLETE, TX_INFO4);
        chk({3'h0, tx.transparent}, 4'h1);
        step(CMD_SWITCH_LOOP, 4'h6, IND_ACT_COMPLETE, TX_INFO4);
        chk({3'h0, tx.loop_close}, 4'h1);
        step(CMD_SYNC_LOST, 4'h6, IND_ACT_COMPLETE, TX_INFO2);
        step(CMD_SWITCH_THROUGH, 4'h6, IND_ACT_COMPLETE, TX_INFO4);
        drive(4'h5, 4'h0);
        chk(ind, IND_RX_UNSYNCED);
        step(CMD_DEACT_REQ, 4'h8, IND_INTERIM_WAIT, TX_INFO0);
        step(CMD_CLEAR, 4'h0, IND_INTERIM_WAIT, TX_INFO0);
    endtask
    task automatic t_lt_activation();
        nt_mode = 1'b0;
        step(CMD_DEACT_CONFIRM, 4'h8, IND_DEACT_DONE, TX_INFO0);
        step(4'h5, 4'h0, IND_RX_UNSYNCED, TX_INFO2);
        step(4'h5, 4'h6, IND_ACT_COMPLETE, TX_INFO4);
        step(4'h5, 4'h0, IND_RX_UNSYNCED, TX_INFO2);
        step(CMD_SWITCH_LOOP, 4'h6, IND_ACT_COMPLETE, TX_INFO4);
        chk({3'h0, tx.loop_close}, 4'h0);
        step(CMD_CLEAR, 4'h6, IND_INTERIM_WAIT, TX_INFO0);
    endtask
    task automatic t_test_modes();
        step(CMD_TEST_SINGLE, 4'h8, IND_INTERIM_WAIT, TX_SINGLE_PULSE);
        wait_for(3, 32000);
        step(CMD_TEST_CONT, 4'h8, IND_INTERIM_WAIT, TX_SINGLE_PULSE);
        step(CMD_DEACT_CONFIRM, 4'h8, IND_DEACT_DONE, TX_INFO0);
        step(CMD_TEST_CONT, 4'h8, IND_INTERIM_WAIT, TX_CONT_PULSE);
        wait_for(0, 2700);
        wait_for(1, 1400);
        step(CMD_CLEAR, 4'h8, IND_INTERIM_WAIT, TX_INFO0);
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial
    begin
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        t_violation();
        t_forced();
        t_nt_activation();
        t_lt_activation();
        t_test_modes();
        tally_and_finish();
    end
endmodule // tb_s_interface_activation_fsm

bind sia_activation_fsm sia_fsm_chk u_chk (.clk_in, .reset_in, .nt_mode_in, .frame_strobe_in, .cmd_code_in,
    .rx_in, .illegal_violation_report_en_in, .sw_control_in, .forced_tx_code_in, .ind_code_out, .tx_out,
    .frame_tick_out);
`default_nettype wire
